/* File: core/tmc_pkg.sv */
// package: register map, field layout, reset values and timing for the timer
package tmc_pkg;
   // register byte offsets on the axi4-lite bus
   localparam logic [3:0] OFF_COUNT  = 4'h0;   // count value
   localparam logic [3:0] OFF_OPTION = 4'h4;   // option bits
   localparam logic [3:0] OFF_STATUS = 4'h8;   // sticky events, w1c
   localparam logic [3:0] OFF_MASK   = 4'hc;   // interrupt mask
   // option field positions
   localparam int OPT_RATE_LSB = 0;            // prescale_rate_field [2:0]
   localparam int OPT_ASSIGN   = 3;            // prescaler_assignment
   localparam int OPT_EDGE     = 4;            // source_edge_select
   localparam int OPT_SOURCE   = 5;            // clock_source_select
   localparam int OPT_WIDTH    = 6;            // option register width
   // status field positions
   localparam int ST_OVF       = 0;            // overflow_flag
   localparam int ST_WIDTH     = 1;            // status register width
   // reset values
   localparam logic [5:0] OPT_RESET   = 6'h3f; // all option bits set
   localparam logic [7:0] COUNT_RESET = 8'h00; // count value at reset
   localparam logic [0:0] MASK_RESET  = 1'h0;  // interrupts masked
   // inhibit window after a write to the count value, in cycles
   localparam logic [1:0] WRITE_INHIBIT = 2'h2;
   // axi response codes
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: core/tmc_edge_sync.sv */
// synchroniser and edge picker for the external count input
`timescale 1ns/1ns
module tmc_edge_sync (
   input  wire logic aclk,                // system clock
   input  wire logic aresetn,             // synchronous reset, active low
   input  wire logic ce,                  // clock enable
   input  wire logic pin_in,              // asynchronous pin
   input  wire logic falling_sel,         // 1 = falling edges count
   output logic      edge_pulse           // one-cycle pulse per edge
);
   logic meta_r;                          // first stage, read by sync_r
   logic sync_r;                          // second stage
   logic prev_r;                          // last synchronised level

   ////////////////////////////////////////////////////////////////////
   // two-stage synchroniser, then a history flop for edge detection
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
      end else if (ce) begin
         meta_r <= pin_in;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   // edge polarity select: falling when set, rising when clear
   always_comb begin
      if (falling_sel) begin
         edge_pulse = ce & prev_r & ~sync_r;
      end else begin
         edge_pulse = ce & ~prev_r & sync_r;
      end
   end
endmodule

/* File: core/tmc_prescaler.sv */
// shared 8-bit prescaler with rate select and hidden count
`timescale 1ns/1ns
module tmc_prescaler #(
   parameter int WIDTH = 8                // prescaler stages
) (
   input  wire logic       aclk,          // system clock
   input  wire logic       aresetn,       // synchronous reset, active low
   input  wire logic       ce,            // clock enable
   input  wire logic       clear,         // zero the hidden count
   input  wire logic       tick_in,       // source events
   input  wire logic [2:0] rate,          // prescale_rate_field
   input  wire logic       to_watchdog,   // assignment: 1 = watchdog
   output logic            tick_out       // divided event
);
   logic [WIDTH-1:0] cnt_r;               // hidden count, no bus access
   logic [WIDTH-1:0] cnt_nxt;             // count after this event
   logic [WIDTH-1:0] lim;                 // terminal value for the ratio
   logic [3:0]       shift;               // log2 of the ratio

   // counter side 1:2..1:256, watchdog side 1:1..1:128
   always_comb begin
      shift   = to_watchdog ? {1'b0, rate} : {1'b0, rate} + 4'h1;
      lim     = WIDTH'((9'h001 << shift) - 9'h001);
      cnt_nxt = cnt_r + WIDTH'(1);
   end

   ////////////////////////////////////////////////////////////////////
   // divide by counting events up to the terminal value
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_r <= '0;
      end else if (ce) begin
         if (clear) begin
            cnt_r <= '0;
         end else if (tick_in) begin
            cnt_r <= (cnt_r >= lim) ? '0 : cnt_nxt;
         end
      end
   end

   // output pulse when an event lands on the terminal value
   always_comb begin
      tick_out = ce & tick_in & ~clear & (cnt_r >= lim);
   end
endmodule

/* File: core/tmc_timer.sv */
// top: 8-bit timer/counter with shared prescaler behind axi4-lite
`timescale 1ns/1ns
module tmc_timer #(
   parameter int PRESCALE_WIDTH = 8       // prescaler stages
) (
   input  wire logic        aclk,         // 250 mhz instruction clock
   input  wire logic        aresetn,      // synchronous reset, active low
   input  wire logic        ce,           // clock enable, freezes state
   input  wire logic        external_count_input, // asynchronous pin
   input  wire logic        watchdog_clear_instruction, // one pulse
   output logic             watchdog_tick, // watchdog event, prescaled when assigned there
   output logic             irq,          // level interrupt
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   ////////////////////////////////////////////////////////////////////
   // declarations
   logic [7:0]  count_value_r;            // the counter
   logic [5:0]  option_r;                 // source, edge, assign, rate
   logic [0:0]  status_r;                 // sticky overflow_flag
   logic [0:0]  mask_r;                   // overflow_interrupt_enable
   logic [1:0]  inhibit_r;                // cycles left without counting
   logic        aw_held_r;                // write address captured
   logic [3:0]  aw_addr_r;                // captured write address
   logic        w_held_r;                 // write data captured
   logic [31:0] w_data_r;                 // captured write data
   logic [3:0]  w_strb_r;                 // captured byte enables
   logic        wr_fire;                  // write commits this cycle
   logic        wr_count;                 // write to the count value
   logic        wr_option;                // write to option
   logic        wr_status;                // write-one-to-clear
   logic        wr_mask;                  // write to mask
   logic        wr_ok;                    // mapped write address
   logic        rd_fire;                  // read accepted this cycle
   logic [31:0] rd_data;                  // read mux
   logic        rd_ok;                    // mapped read address
   logic        ext_edge;                 // synchronised selected edge
   logic        src_tick;                 // selected source event
   logic        pre_out;                  // prescaler output
   logic        pre_clear;                // zero the hidden count
   logic        cnt_tick;                 // counter advance
   logic        to_wdt;                   // prescaler on watchdog side
   logic        overflow;                 // rollover this cycle

   ////////////////////////////////////////////////////////////////////
   // external edge path: two flops then edge select
   tmc_edge_sync u_sync (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .ce          (ce),
      .pin_in      (external_count_input),
      .falling_sel (option_r[tmc_pkg::OPT_EDGE]),
      .edge_pulse  (ext_edge)
   );

   // source select and prescaler steering
   always_comb begin
      to_wdt = option_r[tmc_pkg::OPT_ASSIGN];
      // counter mode takes synchronised edges, timer mode every cycle
      src_tick = option_r[tmc_pkg::OPT_SOURCE] ? ext_edge
                                               : ce;
      // clear the hidden count on a count write (counter side) or a watchdog clear (watchdog side)
      pre_clear = to_wdt ? watchdog_clear_instruction
                         : wr_count;
   end

   // one prescaler; its input comes from whichever side owns it
   tmc_prescaler #(
      .WIDTH       (PRESCALE_WIDTH)
   ) u_pre (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .ce          (ce),
      .clear       (pre_clear),
      .tick_in     (to_wdt ? ce : src_tick),
      .rate        (option_r[tmc_pkg::OPT_RATE_LSB +: 3]),
      .to_watchdog (to_wdt),
      .tick_out    (pre_out)
   );

   // counter gets divided events, or raw events on watchdog assignment
   always_comb begin
      cnt_tick = to_wdt ? src_tick
                        : pre_out;
      overflow = cnt_tick && (inhibit_r == 2'h0) && !wr_count
                 && (count_value_r == 8'hff);
   end

   ////////////////////////////////////////////////////////////////////
   // counter and post-write inhibit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_value_r <= tmc_pkg::COUNT_RESET;
         inhibit_r     <= 2'h0;
      end else if (ce) begin
         if (wr_count) begin
            count_value_r <= w_data_r[7:0];
            inhibit_r     <= tmc_pkg::WRITE_INHIBIT;
         end else if (inhibit_r != 2'h0) begin
            inhibit_r <= inhibit_r - 2'h1;
         end else if (cnt_tick) begin
            count_value_r <= count_value_r + 8'h01;
         end
      end
   end

   // watchdog event out: prescaled only when assigned there
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         watchdog_tick <= 1'b0;
      end else if (ce) begin
         watchdog_tick <= to_wdt ? pre_out : 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // option and mask registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         option_r <= tmc_pkg::OPT_RESET;
         mask_r   <= tmc_pkg::MASK_RESET;
      end else if (ce) begin
         if (wr_option) begin
            option_r <= w_data_r[5:0];   // reassignment order is software's
         end
         if (wr_mask) begin
            mask_r <= w_data_r[0:0];
         end
      end
   end

   // sticky overflow flag; a set in the clearing cycle wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_r <= 1'b0;
      end else if (ce) begin
         if (overflow) begin
            status_r[tmc_pkg::ST_OVF] <= 1'b1;
         end else if (wr_status && w_data_r[tmc_pkg::ST_OVF]) begin
            status_r[tmc_pkg::ST_OVF] <= 1'b0;
         end
      end
   end

   // interrupt level from unmasked sticky bits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else if (ce) begin
         irq <= |(status_r & mask_r);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // axi write decode; low byte lane carries every field
   always_comb begin
      wr_fire   = aw_held_r && w_held_r && !s_axi_bvalid;
      wr_ok     = (aw_addr_r == tmc_pkg::OFF_COUNT) ||
                  (aw_addr_r == tmc_pkg::OFF_OPTION) ||
                  (aw_addr_r == tmc_pkg::OFF_STATUS) ||
                  (aw_addr_r == tmc_pkg::OFF_MASK);
      wr_count  = wr_fire && w_strb_r[0] &&
                  (aw_addr_r == tmc_pkg::OFF_COUNT);
      wr_option = wr_fire && w_strb_r[0] &&
                  (aw_addr_r == tmc_pkg::OFF_OPTION);
      wr_status = wr_fire && w_strb_r[0] &&
                  (aw_addr_r == tmc_pkg::OFF_STATUS);
      wr_mask   = wr_fire && w_strb_r[0] &&
                  (aw_addr_r == tmc_pkg::OFF_MASK);
   end

   // write address and data captured independently, in any order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r     <= 1'b0;
         aw_addr_r     <= 4'h0;
         w_held_r      <= 1'b0;
         w_data_r      <= 32'h0000_0000;
         w_strb_r      <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= tmc_pkg::RESP_OKAY;
      end else if (ce) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         // accept address
         if (s_axi_awvalid && !aw_held_r && !s_axi_awready) begin
            aw_held_r     <= 1'b1;
            aw_addr_r     <= s_axi_awaddr;
            s_axi_awready <= 1'b1;
         end
         // accept data
         if (s_axi_wvalid && !w_held_r && !s_axi_wready) begin
            w_held_r     <= 1'b1;
            w_data_r     <= s_axi_wdata;
            w_strb_r     <= s_axi_wstrb;
            s_axi_wready <= 1'b1;
         end
         // commit and respond
         if (wr_fire) begin
            aw_held_r    <= 1'b0;
            w_held_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? tmc_pkg::RESP_OKAY
                                  : tmc_pkg::RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // axi read mux; prescaler count has no address
   always_comb begin
      rd_fire = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      rd_ok   = 1'b1;
      rd_data = 32'h0000_0000;
      case (s_axi_araddr)
         tmc_pkg::OFF_COUNT:  rd_data[7:0] = count_value_r;
         tmc_pkg::OFF_OPTION: rd_data[5:0] = option_r;
         tmc_pkg::OFF_STATUS: rd_data[0:0] = status_r;
         tmc_pkg::OFF_MASK:   rd_data[0:0] = mask_r;
         default:             rd_ok        = 1'b0;
      endcase
   end

   // read channel: accept and answer on the same edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= tmc_pkg::RESP_OKAY;
      end else if (ce) begin
         s_axi_arready <= 1'b0;
         if (rd_fire) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_data;
            s_axi_rresp   <= rd_ok ? tmc_pkg::RESP_OKAY
                                   : tmc_pkg::RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule

/* File: bench/tmc_timer_properties.sv */
// checker: port-level assertions and covers for the timer block
`timescale 1ns/1ns
module tmc_timer_chk (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        irq,
   input wire logic        watchdog_tick,
   input wire logic        watchdog_clear_instruction,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic [31:0] s_axi_rdata
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////////
   // responses stand until taken, with a steady payload
   a_write_resp_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_read_data_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   // a fresh read is answered in the next cycle
   a_read_answer: assert property (
      $rose(s_axi_arvalid) && !s_axi_rvalid |=> s_axi_arready && s_axi_rvalid)
      else $error("read not answered in one cycle");
   a_write_answer: assert property (
      $rose(s_axi_awvalid && s_axi_wvalid) |-> ##[1:4] s_axi_bvalid)
      else $error("write not answered in time");
   a_ready_one_pulse: assert property (
      s_axi_awready |=> !s_axi_awready)
      else $error("address ready longer than one cycle");
   // only an eight-bit value comes back on the data bus
   a_rdata_upper_zero: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
      else $error("upper read data bits not zero");
   // the interrupt only falls after a software write
   a_irq_sw_clear: assert property (
      $fell(irq) |-> $past(s_axi_bvalid))
      else $error("interrupt fell without a write");
   a_reset_quiet: assert property (
      $rose(aresetn) |-> !irq && !s_axi_bvalid && !s_axi_rvalid)
      else $error("outputs active out of reset");
   ////////////////////////////////////////////////////////////////////
   c_irq: cover property ($rose(irq));
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp[1]);
   c_clear_tick: cover property (watchdog_clear_instruction ##[1:40]
      watchdog_tick);
endmodule
bind tmc_timer tmc_timer_chk chk (.*);

/* File: bench/tmc_pin_model.sv */
// far-side model: drives the external count input pin in bursts
`timescale 1ns/1ns
module tmc_pin_model (
   input  wire logic       aclk,   // system clock
   input  wire logic       go,     // start one burst
   input  wire logic [3:0] n,      // level changes in the burst
   input  wire logic [3:0] hold,   // cycles each level stands
   output logic            pin,    // external count input
   output logic            busy    // burst in progress
);
   // levels stand at least three cycles so the synchroniser sees each
   initial begin
      pin = 1'b0;
      busy = 1'b0;
      forever begin
         @(posedge aclk iff go);
         busy = 1'b1;
         repeat (n) begin
            repeat (hold) @(posedge aclk);
            #1 pin = !pin; // away from the clock edge
         end
         repeat (hold) @(posedge aclk);
         #1 busy = 1'b0;
      end
   end
endmodule

/* File: bench/tmc_timer_tb_top.sv */
// self-checking bench: bus, overflow, prescaler rates, pin counting
`timescale 1ns/1ns
module tmc_timer_tb_top;
   logic        aclk, aresetn, ce, external_count_input, lvl;
   logic        watchdog_clear_instruction, watchdog_tick, irq;
   logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb, n_tog, hold;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, go, busy;
   logic [33:0] rq[$];   // expected {rresp, rdata}
   logic [1:0]  bq[$];   // expected bresp
   int          fails, n_compared, n, x, r;
   localparam logic [1:0] OK = tmc_pkg::RESP_OKAY;
   tmc_timer dut (.*);
   tmc_pin_model pin_m (.aclk(aclk), .go(go), .n(n_tog), .hold(hold),
      .pin(external_count_input), .busy(busy));
   always #2 aclk = ~aclk;
   ////////////////////////////////////////////////////////////////////
   task automatic check(input string w, input logic [31:0] e,
                        input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", w, e, g);
      end
   endtask
   task automatic report_and_stop;
      $display("compared %0d fails %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // bus write: address and data together, response taken late
   task automatic wr(input logic [3:0] a, input logic [7:0] d,
                     input logic [1:0] rs = OK, input logic [3:0] s = 4'hf);
      bit aw = 1'b1;
      bit w = 1'b1;
      bq.push_back(rs);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (aw || w) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         aw = aw && !s_axi_awready;
         w = w && !s_axi_wready;
      end
      @(posedge aclk);
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] d);
      rq.push_back({OK, 24'h00_0000, d});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask
   // cycles until irq (t=0) or the watchdog tick (t=1) is seen high
   task automatic cnt(input bit t);
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while ((t ? watchdog_tick : irq) !== 1'b1);
   endtask
   task automatic wclr;
      watchdog_clear_instruction <= 1'b1;
      @(posedge aclk);
      watchdog_clear_instruction <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////
   // monitor: each response is compared with the oldest note
   always @(posedge aclk) begin
      if (s_axi_rvalid && s_axi_rready) begin
         check("rdata", rq[0][31:0], s_axi_rdata);
         check("rresp", 32'(rq[0][33:32]), 32'(s_axi_rresp));
         void'(rq.pop_front());
      end
      if (s_axi_bvalid && s_axi_bready) begin
         check("bresp", 32'(bq[0]), 32'(s_axi_bresp));
         void'(bq.pop_front());
      end
   end
   initial begin
      #200_000;
      fails++;
      report_and_stop();
   end
   ////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(62445));
      {aclk, aresetn, ce, go, lvl} = 5'h04;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready, watchdog_clear_instruction} = 3'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h00_0000_0000;
      {s_axi_wstrb, n_tog, hold} = 12'hf03;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(tmc_pkg::OFF_COUNT, 8'h00);
      rd(tmc_pkg::OFF_OPTION, 8'h3f);
      rd(tmc_pkg::OFF_STATUS, 8'h00);
      rd(tmc_pkg::OFF_MASK, 8'h00);
      wr(4'h2, 8'hff, tmc_pkg::RESP_SLVERR);
      wr(tmc_pkg::OFF_MASK, 8'h01, OK, 4'h0);
      rd(tmc_pkg::OFF_MASK, 8'h00);
      wr(tmc_pkg::OFF_MASK, 8'h01);
      // timer, undivided: 256-x counts, two inhibit cycles, irq lag
      // and sampling lag, less the two edges the write task spends
      // after its commit edge
      wr(tmc_pkg::OFF_OPTION, 8'h08);
      repeat (3) begin
         x = $urandom_range(200, 250);
         wr(tmc_pkg::OFF_COUNT, x[7:0]);
         cnt(1'b0);
         check("wrap", 32'(258 - x), 32'(n));
         rd(tmc_pkg::OFF_STATUS, 8'h01);
         wr(tmc_pkg::OFF_STATUS, 8'h01);
         rd(tmc_pkg::OFF_STATUS, 8'h00);
      end
      // masked overflow still sets the flag
      wr(tmc_pkg::OFF_MASK, 8'h00);
      wr(tmc_pkg::OFF_COUNT, 8'hf0);
      repeat (40) @(posedge aclk);
      check("irq", 32'h0, 32'(irq));
      rd(tmc_pkg::OFF_STATUS, 8'h01);
      wr(tmc_pkg::OFF_STATUS, 8'h01);
      wr(tmc_pkg::OFF_MASK, 8'h01);
      // prescaler on the counter: four counts of 2^(rate+1)
      for (r = 0; r < 8; r++) begin
         wr(tmc_pkg::OFF_OPTION, r[7:0]);
         check("wdt", 32'h1, 32'(watchdog_tick));
         wr(tmc_pkg::OFF_COUNT, 8'hfc);
         cnt(1'b0);
         x = 4 << (r + 1);
         check("rate", 32'h1, 32'(n >= x - 3 && n <= x + 3));
         wr(tmc_pkg::OFF_STATUS, 8'h01);
      end
      // hand the prescaler to the watchdog in the safe order
      wr(tmc_pkg::OFF_COUNT, 8'h00);
      wr(tmc_pkg::OFF_OPTION, 8'h08);
      wclr();
      wr(tmc_pkg::OFF_OPTION, 8'h0d);
      // counter mode: rising then falling edges of bursts
      for (r = 0; r < 2; r++) begin
         wr(tmc_pkg::OFF_OPTION, 8'h28 | (r[7:0] << 4));
         x = $urandom_range(0, 200);
         wr(tmc_pkg::OFF_COUNT, x[7:0]);
         n_tog <= 4'($urandom_range(3, 9));
         hold <= 4'($urandom_range(3, 8));
         go <= 1'b1;
         @(posedge aclk);
         go <= 1'b0;
         do @(posedge aclk); while (busy);
         repeat (8) @(posedge aclk);
         n = (lvl ^ r[0]) ? n_tog / 2 : (n_tog + 1) / 2;
         rd(tmc_pkg::OFF_COUNT, 8'(x + n));
         lvl = lvl ^ n_tog[0];
      end
      // watchdog side rates 1:1 through 1:128
      for (r = 0; r < 8; r++) begin
         wr(tmc_pkg::OFF_OPTION, 8'h08 | r[7:0]);
         cnt(1'b1);
         cnt(1'b1);
         check("wdt rate", 32'(1 << r), 32'(n));
      end
      // clear restarts a 1:16 watchdog prescale from zero
      wr(tmc_pkg::OFF_OPTION, 8'h0c);
      for (r = 5; r < 10; r += 4) begin
         cnt(1'b1);
         repeat (r) @(posedge aclk);
         wclr();
         cnt(1'b1);
         check("wdt clear", 32'h1, 32'(n >= 14 && n <= 19));
      end
      report_and_stop();
   end
endmodule
